/* mzr_pkg.sv */
// constants and types shared by the mastering / output reduction block
// assumes a single 250 MHz clock and a plain word-wide register port
`default_nettype none

package mzr_pkg;

  // clock and documented times
  localparam int CLK_HZ = 250_000_000;
  localparam int T_WAIT_S = 2;
  localparam int T_LOCK_MIN = 5;
  localparam int T_FLASH_S = 2;
  localparam int KEY_FLASH_HZ = 3;
  localparam int INP_FLASH_HZ = 8;

  // derived cycle counts, flash half periods round down
  localparam int SEC_CYC = CLK_HZ;
  localparam int WAIT_CYC = T_WAIT_S * CLK_HZ;
  localparam int FLASH_CYC = T_FLASH_S * CLK_HZ;
  localparam int LOCK_SEC = T_LOCK_MIN * 60;
  localparam int KEY_HALF_CYC = CLK_HZ / (2 * KEY_FLASH_HZ);
  localparam int INP_HALF_CYC = CLK_HZ / (2 * INP_FLASH_HZ);

  // widths
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int VW = 18;
  localparam int NW = 22;
  localparam int EW = 10;
  localparam int CW = 32;
  localparam int LW = 9;
  localparam int FW = 7;
  localparam int BW = 3;

  // register byte addresses
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_MVAL = 8'h04;
  localparam logic [AW-1:0] OFF_RED_N = 8'h08;
  localparam logic [AW-1:0] OFF_RED_SEL = 8'h0c;
  localparam logic [AW-1:0] OFF_OUT_IF = 8'h10;
  localparam logic [AW-1:0] OFF_FIELD = 8'h14;
  localparam logic [AW-1:0] OFF_BAUD = 8'h18;
  localparam logic [AW-1:0] OFF_KLOCK = 8'h1c;
  localparam logic [AW-1:0] OFF_ERR = 8'h20;
  localparam logic [AW-1:0] OFF_OFFSET = 8'h24;

  // control write bits and status read bits
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_ZERO = 1;
  localparam int CTRL_INACT = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_MASTERED = 1;
  localparam int STAT_LOCKED = 2;

  // reduction select bits, one per output interface
  localparam int SEL_ANA = 0;
  localparam int SEL_SER = 1;
  localparam int SEL_WEB = 2;

  // limits and reset values
  localparam logic [NW-1:0] RED_MIN = 22'h000001;
  localparam logic [NW-1:0] RED_MAX = 22'h2dc6c0;
  localparam logic [BW-1:0] BAUD_LAST = 3'h5;
  localparam logic [BW-1:0] BAUD_RST = 3'h5;
  localparam logic [FW-1:0] FIELD_RST = 7'h01;
  localparam logic [2:0] RED_SEL_RST = 3'h0;
  localparam logic [VW-1:0] ZERO_VAL = 18'h00000;

  // reply codes
  localparam logic [EW-1:0] ERR_NONE = 10'h000;
  localparam logic [EW-1:0] ERR_TIMEOUT = 10'h0dc;
  localparam logic [EW-1:0] ERR_RANGE = 10'h25a;

  typedef enum logic [1:0] {
    IF_WEB = 2'b00,
    IF_ANALOG = 2'b01,
    IF_SERIAL = 2'b10
  } mzr_if_t;

  typedef enum logic [1:0] {
    SRC_REG = 2'b00,
    SRC_KEY = 2'b01,
    SRC_INP = 2'b10
  } mzr_src_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } mzr_state_t;

endpackage : mzr_pkg

`default_nettype wire

/* mzr_reduce.sv */
// every-nth-value pacer for the measurement stream
// assumes step is a one-cycle pulse per measurement value
`default_nettype none

module mzr_reduce (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [mzr_pkg::NW-1:0] red_n,
  input wire logic step,
  output logic keep
);

  typedef struct packed {
    logic [mzr_pkg::NW-1:0] cnt;
  } mzr_red_t;

  mzr_red_t r_reg;
  mzr_red_t r_next;

  // the first value after reset is kept, then every nth one
  assign keep = step && (r_reg.cnt == '0);

  always_comb begin
    r_next = r_reg;
    if (step) begin
      // a shrinking factor must not strand the count above it
      if (r_reg.cnt >= red_n - mzr_pkg::RED_MIN) begin
        r_next.cnt = '0;
      end else begin
        r_next.cnt = r_reg.cnt + mzr_pkg::RED_MIN;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : mzr_reduce

`default_nettype wire

/* mzr_top.sv */
// mastering / zeroing of the measurement value and output data reduction
// assumes one synchronous 250 MHz clock, synchronous inputs, and a measurement
// stream that presents one value per meas_valid pulse
//
// Functional notes
// - on a master command, wait up to 2 s and master the next value
// - no value within the wait ends the command with timeout code 220
// - after mastering, output values relative to the stored master value
// - the inactive setting returns to unshifted, non-mastered output
// - master only a target in range; offset shifts all outputs
// - an invalid captured value is rejected with out-of-range code 602
// - the select key locks 5 min after start; software can release it
// - key presses under lock start nothing
// - a failed key mastering flashes the indicator red at 3 Hz for 2 s
// - a failed input mastering flashes the indicator red at 8 Hz for 2 s
// - a pulse on the functional input starts mastering
// - key and functional input are both accepted as triggers
// - with reduction n only every nth value is output
// - reduction factor accepted from 1 to 3,000,000
// - reduction applies only to interfaces selected for it
// - serial link runs at one selectable baud rate of the set
// - only the enabled output data fields are transmitted
// - zeroing is mastering with a master value of zero
//
// Chosen here: the register addresses and the strobed register port.
`default_nettype none

module mzr_top #(
  parameter int unsigned SEC_CYC = mzr_pkg::SEC_CYC,
  parameter int unsigned WAIT_CYC = mzr_pkg::WAIT_CYC,
  parameter int unsigned FLASH_CYC = mzr_pkg::FLASH_CYC,
  parameter int unsigned KEY_HALF_CYC = mzr_pkg::KEY_HALF_CYC,
  parameter int unsigned INP_HALF_CYC = mzr_pkg::INP_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [mzr_pkg::AW-1:0] reg_addr,
  input wire logic [mzr_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mzr_pkg::DW-1:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic [mzr_pkg::VW-1:0] meas_value,
  input wire logic meas_ok,
  input wire logic key_press,
  input wire logic func_in,
  output logic [mzr_pkg::VW-1:0] val_out,
  output logic ser_valid,
  output logic ana_valid,
  output logic web_valid,
  output logic [mzr_pkg::FW-1:0] field_en,
  output logic [mzr_pkg::BW-1:0] baud_sel,
  output logic led_red,
  output logic key_locked,
  output logic mastered
);

  typedef struct packed {
    mzr_pkg::mzr_state_t state;
    mzr_pkg::mzr_src_t src;
    logic zero_req;
    logic [mzr_pkg::VW-1:0] master_val;
    logic [mzr_pkg::NW-1:0] red_n;
    logic [2:0] red_sel;
    mzr_pkg::mzr_if_t out_if;
    logic [mzr_pkg::FW-1:0] field;
    logic [mzr_pkg::BW-1:0] baud;
    logic lock_en;
    logic lock_done;
    logic [mzr_pkg::LW-1:0] lock_sec;
    logic [mzr_pkg::CW-1:0] sec_cnt;
    logic mastered;
    logic [mzr_pkg::VW-1:0] offset;
    logic [mzr_pkg::EW-1:0] err;
    logic [mzr_pkg::CW-1:0] wait_cnt;
    logic flashing;
    logic led_on;
    logic [mzr_pkg::CW-1:0] flash_cnt;
    logic [mzr_pkg::CW-1:0] half_cnt;
    logic [mzr_pkg::CW-1:0] half_len;
    logic key_q;
    logic inp_q;
    logic [mzr_pkg::DW-1:0] rdata;
    logic [mzr_pkg::VW-1:0] val;
    logic ser_v;
    logic ana_v;
    logic web_v;
  } mzr_state_reg_t;

  mzr_state_reg_t r_reg;
  mzr_state_reg_t r_next;
  logic keep;
  logic locked;
  logic key_rise;
  logic inp_rise;
  logic cmd_master;
  logic cmd_zero;
  logic fail;
  logic [mzr_pkg::VW-1:0] target;

  mzr_reduce u_reduce (
    .mclk(mclk),
    .rst(rst),
    .red_n(r_reg.red_n),
    .step(meas_valid),
    .keep(keep)
  );

  assign locked = r_reg.lock_en && r_reg.lock_done;
  assign key_rise = key_press && !r_reg.key_q;
  assign inp_rise = func_in && !r_reg.inp_q;

  always_comb begin
    r_next = r_reg;
    cmd_master = 1'b0;
    cmd_zero = 1'b0;
    fail = 1'b0;
    target = r_reg.zero_req ? mzr_pkg::ZERO_VAL : r_reg.master_val;
    r_next.key_q = key_press;
    r_next.inp_q = func_in;
    r_next.ser_v = 1'b0;
    r_next.ana_v = 1'b0;
    r_next.web_v = 1'b0;
    r_next.rdata = '0;

    // power-on key lock timer, one-second enable from a divider
    if (!r_reg.lock_done) begin
      if (r_reg.sec_cnt == mzr_pkg::CW'(SEC_CYC - 1)) begin
        r_next.sec_cnt = '0;
        if (r_reg.lock_sec == mzr_pkg::LW'(mzr_pkg::LOCK_SEC - 1)) begin
          r_next.lock_done = 1'b1;
        end else begin
          r_next.lock_sec = r_reg.lock_sec + 1'b1;
        end
      end else begin
        r_next.sec_cnt = r_reg.sec_cnt + 1'b1;
      end
    end

    // failure indication: red blink of chosen half period for a fixed span
    if (r_reg.flashing) begin
      if (r_reg.half_cnt == r_reg.half_len) begin
        r_next.half_cnt = '0;
        r_next.led_on = !r_reg.led_on;
      end else begin
        r_next.half_cnt = r_reg.half_cnt + 1'b1;
      end
      if (r_reg.flash_cnt == mzr_pkg::CW'(FLASH_CYC - 1)) begin
        r_next.flashing = 1'b0;
        r_next.led_on = 1'b0;
      end else begin
        r_next.flash_cnt = r_reg.flash_cnt + 1'b1;
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        mzr_pkg::OFF_CTRL: begin
          cmd_master = reg_wdata[mzr_pkg::CTRL_MASTER];
          cmd_zero = reg_wdata[mzr_pkg::CTRL_ZERO];
          if (reg_wdata[mzr_pkg::CTRL_INACT]) begin
            r_next.mastered = 1'b0;
            r_next.offset = '0;
          end
        end
        mzr_pkg::OFF_MVAL: r_next.master_val = reg_wdata[mzr_pkg::VW-1:0];
        mzr_pkg::OFF_RED_N: begin
          // out-of-range factors are dropped, the old one stays
          if (reg_wdata[mzr_pkg::DW-1:mzr_pkg::NW] == '0 &&
              reg_wdata[mzr_pkg::NW-1:0] >= mzr_pkg::RED_MIN &&
              reg_wdata[mzr_pkg::NW-1:0] <= mzr_pkg::RED_MAX) begin
            r_next.red_n = reg_wdata[mzr_pkg::NW-1:0];
          end
        end
        mzr_pkg::OFF_RED_SEL: r_next.red_sel = reg_wdata[2:0];
        mzr_pkg::OFF_OUT_IF: begin
          case (reg_wdata[1:0])
            mzr_pkg::IF_WEB: r_next.out_if = mzr_pkg::IF_WEB;
            mzr_pkg::IF_ANALOG: r_next.out_if = mzr_pkg::IF_ANALOG;
            mzr_pkg::IF_SERIAL: r_next.out_if = mzr_pkg::IF_SERIAL;
            default: ;
          endcase
        end
        mzr_pkg::OFF_FIELD: r_next.field = reg_wdata[mzr_pkg::FW-1:0];
        mzr_pkg::OFF_BAUD: begin
          if (reg_wdata[mzr_pkg::DW-1:mzr_pkg::BW] == '0 &&
              reg_wdata[mzr_pkg::BW-1:0] <= mzr_pkg::BAUD_LAST) begin
            r_next.baud = reg_wdata[mzr_pkg::BW-1:0];
          end
        end
        mzr_pkg::OFF_KLOCK: r_next.lock_en = reg_wdata[0];
        default: ;
      endcase
    end

    // register reads, data in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        mzr_pkg::OFF_CTRL: begin
          r_next.rdata[mzr_pkg::STAT_BUSY] = (r_reg.state == mzr_pkg::ST_WAIT);
          r_next.rdata[mzr_pkg::STAT_MASTERED] = r_reg.mastered;
          r_next.rdata[mzr_pkg::STAT_LOCKED] = locked;
        end
        mzr_pkg::OFF_MVAL: r_next.rdata[mzr_pkg::VW-1:0] = r_reg.master_val;
        mzr_pkg::OFF_RED_N: r_next.rdata[mzr_pkg::NW-1:0] = r_reg.red_n;
        mzr_pkg::OFF_RED_SEL: r_next.rdata[2:0] = r_reg.red_sel;
        mzr_pkg::OFF_OUT_IF: r_next.rdata[1:0] = r_reg.out_if;
        mzr_pkg::OFF_FIELD: r_next.rdata[mzr_pkg::FW-1:0] = r_reg.field;
        mzr_pkg::OFF_BAUD: r_next.rdata[mzr_pkg::BW-1:0] = r_reg.baud;
        mzr_pkg::OFF_KLOCK: r_next.rdata[0] = r_reg.lock_en;
        mzr_pkg::OFF_ERR: r_next.rdata[mzr_pkg::EW-1:0] = r_reg.err;
        mzr_pkg::OFF_OFFSET: r_next.rdata[mzr_pkg::VW-1:0] = r_reg.offset;
        default: r_next.rdata = '0;
      endcase
    end

    // mastering sequence
    case (r_reg.state)
      mzr_pkg::ST_IDLE: begin
        r_next.wait_cnt = '0;
        if (cmd_master || cmd_zero) begin
          r_next.state = mzr_pkg::ST_WAIT;
          r_next.src = mzr_pkg::SRC_REG;
          r_next.zero_req = cmd_zero && !cmd_master;
        end else if (key_rise && !locked) begin
          r_next.state = mzr_pkg::ST_WAIT;
          r_next.src = mzr_pkg::SRC_KEY;
          r_next.zero_req = 1'b0;
        end else if (inp_rise) begin
          r_next.state = mzr_pkg::ST_WAIT;
          r_next.src = mzr_pkg::SRC_INP;
          r_next.zero_req = 1'b0;
        end
      end
      mzr_pkg::ST_WAIT: begin
        // fresh requests are not queued while one is pending
        if (meas_valid) begin
          r_next.state = mzr_pkg::ST_IDLE;
          if (meas_ok) begin
            r_next.offset = target - meas_value;
            r_next.mastered = 1'b1;
            r_next.err = mzr_pkg::ERR_NONE;
          end else begin
            r_next.err = mzr_pkg::ERR_RANGE;
            fail = 1'b1;
          end
        end else if (r_reg.wait_cnt == mzr_pkg::CW'(WAIT_CYC - 1)) begin
          r_next.state = mzr_pkg::ST_IDLE;
          r_next.err = mzr_pkg::ERR_TIMEOUT;
          fail = 1'b1;
        end else begin
          r_next.wait_cnt = r_reg.wait_cnt + 1'b1;
        end
      end
      default: r_next.state = mzr_pkg::ST_IDLE;
    endcase

    // register-started failures only report through the error code
    if (fail && r_reg.src != mzr_pkg::SRC_REG) begin
      r_next.flashing = 1'b1;
      r_next.led_on = 1'b1;
      r_next.flash_cnt = '0;
      r_next.half_cnt = '0;
      if (r_reg.src == mzr_pkg::SRC_KEY) begin
        r_next.half_len = mzr_pkg::CW'(KEY_HALF_CYC - 1);
      end else begin
        r_next.half_len = mzr_pkg::CW'(INP_HALF_CYC - 1);
      end
    end

    // output path: shift, then route to the one selected interface
    if (meas_valid) begin
      if (r_reg.mastered) begin
        r_next.val = meas_value + r_reg.offset;
      end else begin
        r_next.val = meas_value;
      end
      case (r_reg.out_if)
        mzr_pkg::IF_SERIAL: begin
          r_next.ser_v = !r_reg.red_sel[mzr_pkg::SEL_SER] || keep;
        end
        mzr_pkg::IF_ANALOG: begin
          r_next.ana_v = !r_reg.red_sel[mzr_pkg::SEL_ANA] || keep;
        end
        mzr_pkg::IF_WEB: begin
          r_next.web_v = !r_reg.red_sel[mzr_pkg::SEL_WEB] || keep;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.red_n <= mzr_pkg::RED_MIN;
      r_reg.red_sel <= mzr_pkg::RED_SEL_RST;
      r_reg.out_if <= mzr_pkg::IF_SERIAL;
      r_reg.field <= mzr_pkg::FIELD_RST;
      r_reg.baud <= mzr_pkg::BAUD_RST;
      r_reg.lock_en <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign val_out = r_reg.val;
  assign ser_valid = r_reg.ser_v;
  assign ana_valid = r_reg.ana_v;
  assign web_valid = r_reg.web_v;
  assign field_en = r_reg.field;
  assign baud_sel = r_reg.baud;
  assign led_red = r_reg.led_on;
  assign key_locked = locked;
  assign mastered = r_reg.mastered;

endmodule : mzr_top

`default_nettype wire

/* mzr_host_model.sv */
// operator and sensor-front model: measurement strobes, key and input pulses
// assumes its tasks are called just after a rising mclk edge
`default_nettype none
module mzr_host_model (
  input wire logic mclk,
  output logic meas_valid,
  output logic [mzr_pkg::VW-1:0] meas_value,
  output logic meas_ok,
  output logic key_press,
  output logic func_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    meas_valid = 1'b0;
    meas_value = '0;
    meas_ok = 1'b0;
    key_press = 1'b0;
    func_in = 1'b0;
  end
  // value lines turn to junk outside the strobe, so a stale value never passes
  task automatic meas(input logic [mzr_pkg::VW-1:0] v, input logic ok);
    meas_valid <= 1'b1;
    meas_value <= v;
    meas_ok <= ok;
    @(posedge mclk);
    meas_valid <= 1'b0;
    meas_value <= ~v;
    meas_ok <= ~ok;
  endtask : meas
  task automatic trig(input bit key);
    repeat (12) @(posedge mclk);
    if (key) key_press <= 1'b1;
    else func_in <= 1'b1;
    repeat (3) @(posedge mclk);
    key_press <= 1'b0;
    func_in <= 1'b0;
  endtask : trig
endmodule : mzr_host_model
`default_nettype wire

/* mzr_top_asserts.sv */
// port assertions for the mastering / reduction block
// assumes a bind into mzr_top and a synchronous active-high reset
`default_nettype none
module mzr_top_asserts #(
  parameter int unsigned SEC_CYC = mzr_pkg::SEC_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [mzr_pkg::DW-1:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic [mzr_pkg::VW-1:0] meas_value,
  input wire logic meas_ok,
  input wire logic [mzr_pkg::VW-1:0] val_out,
  input wire logic ser_valid,
  input wire logic ana_valid,
  input wire logic web_valid,
  input wire logic [mzr_pkg::BW-1:0] baud_sel,
  input wire logic led_red,
  input wire logic key_locked,
  input wire logic mastered
);
  timeunit 1ns;
  timeprecision 1ps;
  // saturating cycle count since reset, wide enough for the full lock time at 250 MHz
  localparam logic [39:0] LOCK_CYC = 40'(mzr_pkg::LOCK_SEC) * 40'(SEC_CYC);
  logic [39:0] up_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      up_reg <= 40'h0;
    end else if (up_reg != 40'hffffffffff) begin
      up_reg <= up_reg + 40'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_one_iface: assert property ($onehot0({ser_valid, ana_valid, web_valid}))
    else $error("several interfaces pulsed at once");
  a_valid_cause: assert property ((ser_valid || ana_valid || web_valid) |-> $past(meas_valid))
    else $error("output pulse without a measurement");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside the answer cycle");
  a_val_hold: assert property (!$past(meas_valid) |-> $stable(val_out))
    else $error("output value moved without a measurement");
  a_raw_pass: assert property ((meas_valid && !mastered) ##1 !mastered |->
    val_out == $past(meas_value)) else $error("unmastered value was shifted");
  a_baud_range: assert property (baud_sel <= mzr_pkg::BAUD_LAST)
    else $error("baud index out of set");
  a_master_rise: assert property ($rose(mastered) |-> $past(meas_valid && meas_ok))
    else $error("mastered without a valid target");
  a_fail_keep: assert property (meas_valid && !meas_ok |=> $stable(mastered))
    else $error("invalid value changed master state");
  a_lock_time: assert property ($rose(key_locked) |->
    up_reg + 40'h2 >= LOCK_CYC && up_reg <= LOCK_CYC + 40'h2) else $error("key lock off time");
  c_master: cover property ($rose(mastered));
  c_flash: cover property ($rose(led_red));
  c_lock: cover property ($rose(key_locked));
endmodule : mzr_top_asserts
bind mzr_top mzr_top_asserts #(.SEC_CYC(SEC_CYC)) mzr_top_asserts_inst (
  .mclk(mclk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
  .meas_value(meas_value), .meas_ok(meas_ok), .val_out(val_out), .ser_valid(ser_valid),
  .ana_valid(ana_valid), .web_valid(web_valid), .baud_sel(baud_sel), .led_red(led_red),
  .key_locked(key_locked), .mastered(mastered)
);
`default_nettype wire

/* mzr_top_tb.sv */
// self-checking bench: registers, mastering, flashing, lock, reduction
// assumes the host model drives measurement and trigger pins
`default_nettype none
module mzr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 60;
  localparam int KH = 6;
  localparam int IH = 3;
  logic mclk, rst, reg_wr, reg_rd, meas_valid, meas_ok, key_press, func_in;
  logic ser_valid, ana_valid, web_valid, led_red, key_locked, mastered, m;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [17:0] meas_value, val_out, off, mv, v;
  logic [6:0] field_en;
  logic [2:0] baud_sel;
  int err_total = 0;
  int n_tests = 0;
  int seed = 82632;
  logic [7:0] ra [10] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
  logic [31:0] rv [10] = '{0, 1, 0, 2, 1, 5, 1, 0, 0, 0};
  logic [7:0] ba [4] = '{8'h08, 8'h08, 8'h18, 8'h10};
  logic [31:0] bd [4] = '{0, 32'h2dc6c1, 6, 3};
  logic [31:0] be [4] = '{1, 1, 5, 2};
  mzr_top #(.SEC_CYC(10), .WAIT_CYC(50), .FLASH_CYC(FC), .KEY_HALF_CYC(KH),
    .INP_HALF_CYC(IH)) mzr_top_inst (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_ok(meas_ok), .key_press(key_press), .func_in(func_in), .val_out(val_out),
    .ser_valid(ser_valid), .ana_valid(ana_valid), .web_valid(web_valid), .field_en(field_en),
    .baud_sel(baud_sel), .led_red(led_red), .key_locked(key_locked), .mastered(mastered));
  mzr_host_model host_inst (.mclk(mclk), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_ok(meas_ok), .key_press(key_press), .func_in(func_in));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [17:0] shf(input logic [17:0] x);
    return x + (m ? off : 18'h0);
  endfunction : shf
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // one idle edge, so a following call never re-drives the strobe in the same step
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, e);
  endtask : rd
  task automatic burst(input int k, input int es, input int ea, input int ew);
    logic [17:0] x;
    int s = 0;
    int a = 0;
    int w = 0;
    repeat (k) begin
      x = 18'($random(seed));
      host_inst.meas(x, 1'b1);
      @(posedge mclk);
      chk(val_out, shf(x));
      s += (ser_valid === 1'b1);
      a += (ana_valid === 1'b1);
      w += (web_valid === 1'b1);
    end
    chk({s[7:0], a[7:0], w[7:0]}, {es[7:0], ea[7:0], ew[7:0]});
  endtask : burst
  task automatic mreg(input logic [31:0] c, input logic ok);
    logic [17:0] x;
    x = 18'($random(seed));
    mv = 18'($random(seed));
    repeat (12) @(posedge mclk);
    wr(8'h04, {14'h0, mv});
    wr(8'h00, c);
    host_inst.meas(x, ok);
    @(posedge mclk);
    if (ok) begin
      m = 1'b1;
      off = (c[1] ? 18'h0 : mv) - x;
    end
    chk(mastered, m);
    rd(8'h20, ok ? 32'h0 : 32'h25a);
    if (m) rd(8'h24, {14'h0, off});
  endtask : mreg
  task automatic trg(input bit key, input logic ok, input int half, input bit lk);
    logic [17:0] x;
    int r = 0;
    bit p = 1'b0;
    x = 18'($random(seed));
    host_inst.trig(key);
    host_inst.meas(x, ok);
    if (ok && !lk) begin
      m = 1'b1;
      off = mv - x;
    end
    repeat (FC + 8) begin
      @(posedge mclk);
      r += (led_red === 1'b1) && !p;
      p = (led_red === 1'b1);
    end
    chk(mastered, m);
    chk(r, ok ? 0 : FC / (2 * half));
  endtask : trg
  initial begin
    repeat (10000) @(posedge mclk);
    err_total++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    m = 1'b0;
    off = 18'h0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 4; i++) begin
      wr(ba[i], bd[i]);
      rd(ba[i], be[i]);
    end
    wr(8'h08, 32'h2dc6c0);
    rd(8'h08, 32'h2dc6c0);
    wr(8'h08, 32'h1);
    for (int i = 0; i < 6; i++) begin
      v = 18'($random(seed));
      wr(8'h18, i);
      wr(8'h14, {25'h0, v[6:0]});
      @(posedge mclk);
      chk(baud_sel, i);
      chk(field_en, v[6:0]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, i);
      burst(4, i == 2 ? 4 : 0, i == 1 ? 4 : 0, i == 0 ? 4 : 0);
    end
    mreg(32'h1, 1'b1);
    burst(2, 2, 0, 0);
    mreg(32'h1, 1'b0);
    burst(2, 2, 0, 0);
    repeat (12) @(posedge mclk);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h3);
    repeat (50) @(posedge mclk);
    rd(8'h20, 32'h0dc);
    chk(mastered, m);
    mreg(32'h2, 1'b1);
    burst(2, 2, 0, 0);
    trg(1'b1, 1'b0, KH, 1'b0);
    trg(1'b0, 1'b0, IH, 1'b0);
    trg(1'b1, 1'b1, KH, 1'b0);
    burst(2, 2, 0, 0);
    trg(1'b0, 1'b1, IH, 1'b0);
    wr(8'h00, 32'h4);
    m = 1'b0;
    burst(2, 2, 0, 0);
    chk(mastered, 1'b0);
    wr(8'h08, 32'h3);
    wr(8'h0c, 32'h2);
    burst(9, 3, 0, 0);
    wr(8'h10, 32'h1);
    burst(9, 0, 9, 0);
    wr(8'h0c, 32'h1);
    burst(9, 0, 3, 0);
    wr(8'h08, 32'h1);
    burst(3, 0, 3, 0);
    for (int i = 0; i < 3200 && key_locked !== 1'b1; i++) @(posedge mclk);
    chk(key_locked, 1'b1);
    rd(8'h00, 32'h4);
    trg(1'b1, 1'b1, KH, 1'b1);
    wr(8'h1c, 32'h0);
    @(posedge mclk);
    chk(key_locked, 1'b0);
    conclude();
  end
endmodule : mzr_top_tb
`default_nettype wire
